// ### hdl/arithmetic_element_sequencer.sv
// arithmetic element register transfers and self-timed shift sequencer
//
// Behaviour
// - code 7421: clear quotient in step one, load accumulator in step two, accumulator zero
// - transfer enable when bits 11, 07 one, 04 zero, second operate phase
// - transfer enable suppresses accumulator output enable, accumulator loads zero
// - code 7441: step counter ORed into accumulator in step two
// - counter output enable when bits 11 and 06 one in second phase
// - begin for unnormalized normalize, or operate class in execute cycle
// - time pulse three with begin, not counter load: start sets on and run
// - start emerges as shift pulse after 350 ns, recirculates while run set
// - run reclocked from on at the 450 ns tap
// - each shift pulse drops time generator for 100 ns: one quotient and counter load
// - completion with run set drops on input; next shift pulse clears on
// - next run clock after on clears clears run; time generator left set
// - shift pulses arriving with run clear are blocked
// - first shift pulse after completion clears end, which sets time state four
// - multiply completes when counter bits 1, 3, 4 are one
// - divide completes on counter zero with adder carry (overflow)
// - divide also completes when counter bits 1, 2, 4 are one
// - shifts load complement of count; complete when counter full
// - normalize completes on bits 01/02 = 0/1, or bit 03 zero and rest zero
// - low, mid and quotient-low zero flags from accumulator and quotient bits
// - one more shift follows completion, so normalize tests bits 01 and 02
// - normalize with bits 01/02 = 1/0 ends by losing the shift pulse
// - step one at or before time state three, step two at pulse three
// - quotient load in step two when bit 07 and instruction decode set
// - each counter load during a sequence increments the step counter
`timescale 1ns/1ns

module arithmetic_element_sequencer (
  // clock, reset, enable
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_ce,
  // wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [3:0]  i_wb_sel,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // processor timing and instruction
  input  wire logic [11:0] i_memory_buffer,
  input  wire logic        i_second_operate_phase,
  input  wire logic        i_time_pulse_three,
  input  wire logic        i_step_one,
  input  wire logic        i_operate_class,
  input  wire logic        i_execute_cycle,
  input  wire logic        i_eae_decode,
  // operation selects
  input  wire logic        i_multiply_op,
  input  wire logic        i_divide_op,
  input  wire logic        i_normalize_op,
  input  wire logic        i_shift_op,
  input  wire logic        i_counter_load_op,
  // accumulator side
  input  wire logic [11:0] i_accumulator,
  input  wire logic        i_adder_carry,
  // transfer controls to the processor
  output logic             o_transfer_enable,
  output logic             o_accum_out_enable,
  output logic             o_counter_out_enable,
  output logic      [11:0] o_counter_to_accum,
  output logic      [11:0] o_quotient,
  output logic      [4:0]  o_step_counter,
  // sequencer outputs
  output logic             o_shift_pulse,
  output logic             o_quotient_load,
  output logic             o_counter_load,
  output logic             o_time_state_four,
  output logic             o_seq_on_flag,
  output logic             o_seq_run_flag,
  output logic             o_seq_end_flag,
  output logic             o_time_generator_flag
);

  localparam int DLEN = eae_pkg::RUN_CLK_CYC;

  logic [DLEN-1:0] delay_q;
  logic            on_q;
  logic            run_q;
  logic            end_q;
  logic            tg_q;
  logic            ts4_q;
  logic            shift_q;
  logic            qload_q;
  logic            cload_q;
  logic            xfer_q;
  logic            acc_en_q;
  logic            cnt_en_q;
  logic [11:0]     cnt_acc_q;
  logic [11:0]     mq_q;
  logic [4:0]      sc_q;
  logic [31:0]     ctrl_q;
  logic [31:0]     rdat_q;
  logic            ack_q;

  logic            xfer_d;
  logic            low_accum_zero;
  logic            mid_accum_zero;
  logic            quotient_low_accum_zero;
  logic            normalized_cond;
  logic            seq_begin;
  logic            seq_start_pulse;
  logic            seq_complete;
  logic            raw_tp;
  logic            lost_tp;
  logic            shift_pulse;
  logic            run_clock;
  logic            wb_req;

  // instruction decodes
  // transfer enable decode
  assign xfer_d = i_memory_buffer[eae_pkg::MB_BIT11] & i_memory_buffer[eae_pkg::MB_BIT07]
                & ~i_memory_buffer[eae_pkg::MB_BIT04] & i_second_operate_phase;

  // zero detectors for the normalize test
  // zero flag tree
  assign low_accum_zero          = ~|i_accumulator[3:0];
  assign mid_accum_zero          = ~|i_accumulator[7:4];
  assign quotient_low_accum_zero = ~|mq_q & low_accum_zero;

  // operand already normalized: sign differs from first data bit, or bits 02 to 11 and the quotient all zero
  assign normalized_cond = (i_accumulator[eae_pkg::AC_BIT00] ^ i_accumulator[eae_pkg::AC_BIT01])
                         | (~i_accumulator[eae_pkg::AC_BIT02] & ~i_accumulator[eae_pkg::AC_BIT03]
                            & mid_accum_zero & quotient_low_accum_zero);

  assign seq_begin = (i_normalize_op & ~normalized_cond) | (i_operate_class & i_execute_cycle);

  // a new start is ignored while a sequence is still on; a start less than 350 ns after completion doubles the chain
  // start pulse
  assign seq_start_pulse = i_time_pulse_three & seq_begin & ~i_counter_load_op
                         & ctrl_q[eae_pkg::CTRL_ENABLE] & ~on_q;

  // completion terms per operation
  always_comb begin
    seq_complete = 1'b0;
    if (i_multiply_op && sc_q[eae_pkg::SC_BIT1] && sc_q[eae_pkg::SC_BIT3]
        && sc_q[eae_pkg::SC_BIT4]) begin
      seq_complete = 1'b1;
    end
    if (i_divide_op && sc_q == '0 && i_adder_carry) begin
      seq_complete = 1'b1;
    end
    if (i_divide_op && sc_q[eae_pkg::SC_BIT1] && sc_q[eae_pkg::SC_BIT2]
        && sc_q[eae_pkg::SC_BIT4]) begin
      seq_complete = 1'b1;
    end
    if (i_shift_op && (&sc_q[eae_pkg::SC_BIT1:eae_pkg::SC_BIT4]) && sc_q[eae_pkg::SC_BIT0]) begin
      seq_complete = 1'b1;
    end
    // bits 01/02 are tested because one more shift follows
    // normalize stop
    if (i_normalize_op && ((~i_accumulator[eae_pkg::AC_BIT01] & i_accumulator[eae_pkg::AC_BIT02])
        | (~i_accumulator[eae_pkg::AC_BIT03] & quotient_low_accum_zero & mid_accum_zero))) begin
      seq_complete = 1'b1;
    end
  end

  // delay chain taps
  assign raw_tp    = delay_q[eae_pkg::SHIFT_CYC-1];
  assign run_clock = delay_q[DLEN-1];

  assign lost_tp = raw_tp & run_q & i_normalize_op
                 & i_accumulator[eae_pkg::AC_BIT01] & ~i_accumulator[eae_pkg::AC_BIT02];

  assign shift_pulse = raw_tp & run_q & ~lost_tp;

  // delay line: start or a gated shift pulse enters, taps at 350 and 450 ns
  // recirculating chain
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      delay_q <= '0;
    end else if (i_ce) begin
      delay_q <= {delay_q[DLEN-2:0], seq_start_pulse | shift_pulse};
    end
  end

  // on flag: clocked by start and shift pulses, data low on completion with run
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      on_q <= 1'b0;
    end else if (i_ce) begin
      if (seq_start_pulse) begin
        on_q <= 1'b1;
      end else if (lost_tp) begin
        on_q <= 1'b0;
      end else if (shift_pulse) begin
        on_q <= ~(seq_complete & run_q);
      end
    end
  end

  // run flag: set directly by start, reclocked from on at the late tap
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      run_q <= 1'b0;
    end else if (i_ce) begin
      if (seq_start_pulse) begin
        run_q <= 1'b1;
      end else if (lost_tp) begin
        run_q <= 1'b0;
      end else if (run_clock) begin
        run_q <= on_q;
      end
    end
  end

  // time generator: dropped by each shift pulse, set again by the late tap
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tg_q <= 1'b1;
    end else if (i_ce) begin
      if (run_clock) begin
        tg_q <= 1'b1;
      end else if (shift_pulse) begin
        tg_q <= 1'b0;
      end
    end
  end

  // end flag and the processor resume pulse
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      end_q <= 1'b0;
      ts4_q <= 1'b0;
    end else if (i_ce) begin
      ts4_q <= 1'b0;
      if (seq_start_pulse) begin
        end_q <= 1'b1;
      end else if (lost_tp) begin
        end_q <= 1'b0;
        ts4_q <= end_q;
      end else if (shift_pulse && seq_complete) begin
        end_q <= 1'b0;
        ts4_q <= end_q;
      end
    end
  end

  // per-shift strobes, one cycle each, in the cycle the time generator drops
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      shift_q <= 1'b0;
      qload_q <= 1'b0;
      cload_q <= 1'b0;
    end else if (i_ce) begin
      shift_q <= shift_pulse;
      qload_q <= shift_pulse | (i_time_pulse_three & i_eae_decode
                                & i_memory_buffer[eae_pkg::MB_BIT07]);
      cload_q <= shift_pulse;
    end
  end

  // step counter: preset at start, counts shifts
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sc_q <= '0;
    end else if (i_ce) begin
      if (seq_start_pulse) begin
        sc_q <= i_shift_op ? ~i_memory_buffer[eae_pkg::SC_W-1:0] : '0;
      end else if (shift_pulse) begin
        sc_q <= sc_q + 5'h01;
      end
    end
  end

  // quotient register transfers; shift datapath lives elsewhere
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mq_q <= '0;
    end else if (i_ce) begin
      if (i_time_pulse_three && i_eae_decode && i_memory_buffer[eae_pkg::MB_BIT07]) begin
        mq_q <= xfer_d ? i_accumulator : '0;
      end else if (i_step_one && i_memory_buffer == eae_pkg::LOAD_QUOTIENT_CODE) begin
        mq_q <= '0;
      end
    end
  end

  // accumulator-side enables, registered for clean outputs
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      xfer_q    <= 1'b0;
      acc_en_q  <= 1'b0;
      cnt_en_q  <= 1'b0;
      cnt_acc_q <= '0;
    end else if (i_ce) begin
      xfer_q   <= xfer_d;
      acc_en_q <= i_second_operate_phase & ~xfer_d & ~i_memory_buffer[eae_pkg::MB_BIT04];
      cnt_en_q <= i_memory_buffer[eae_pkg::MB_BIT11] & i_memory_buffer[eae_pkg::MB_BIT06]
                & i_second_operate_phase;
      if (i_memory_buffer[eae_pkg::MB_BIT11] && i_memory_buffer[eae_pkg::MB_BIT06]
          && i_second_operate_phase) begin
        cnt_acc_q <= {7'h00, sc_q};
      end else begin
        cnt_acc_q <= '0;
      end
    end
  end

  // wishbone slave: one wait state, ack drops the cycle after
  assign wb_req = i_wb_cyc & i_wb_stb & ~ack_q;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ack_q <= 1'b0;
    end else if (i_ce) begin
      ack_q <= wb_req;
    end
  end

  // control register, byte lanes honoured
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_q <= eae_pkg::CTRL_RESET;
    end else if (i_ce && wb_req && i_wb_we && i_wb_adr == eae_pkg::CTRL_ADDR) begin
      for (int b = 0; b < 4; b++) begin
        if (i_wb_sel[b]) begin
          ctrl_q[8*b +: 8] <= i_wb_dat[8*b +: 8];
        end
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdat_q <= '0;
    end else if (i_ce) begin
      rdat_q <= '0;
      if (wb_req && !i_wb_we) begin
        case (i_wb_adr)
          eae_pkg::CTRL_ADDR: begin
            rdat_q <= ctrl_q;
          end
          eae_pkg::STATUS_ADDR: begin
            rdat_q[eae_pkg::ST_ON]       <= on_q;
            rdat_q[eae_pkg::ST_RUN]      <= run_q;
            rdat_q[eae_pkg::ST_END]      <= end_q;
            rdat_q[eae_pkg::ST_TG]       <= tg_q;
            rdat_q[eae_pkg::ST_COMPLETE] <= seq_complete;
          end
          eae_pkg::COUNT_ADDR: begin
            rdat_q[eae_pkg::COUNT_SC_LSB +: 5]  <= sc_q;
            rdat_q[eae_pkg::COUNT_MQ_LSB +: 12] <= mq_q;
          end
          default: begin
            rdat_q <= '0;
          end
        endcase
      end
    end
  end

  // outputs straight from flops
  assign o_wb_dat              = rdat_q;
  assign o_wb_ack              = ack_q;
  assign o_transfer_enable     = xfer_q;
  assign o_accum_out_enable    = acc_en_q;
  assign o_counter_out_enable  = cnt_en_q;
  assign o_counter_to_accum    = cnt_acc_q;
  assign o_quotient            = mq_q;
  assign o_step_counter        = sc_q;
  assign o_shift_pulse         = shift_q;
  assign o_quotient_load       = qload_q;
  assign o_counter_load        = cload_q;
  assign o_time_state_four     = ts4_q;
  assign o_seq_on_flag         = on_q;
  assign o_seq_run_flag        = run_q;
  assign o_seq_end_flag        = end_q;
  assign o_time_generator_flag = tg_q;

  // checks; a frozen clock enable suspends them
  // flags are seen one cycle after start, so the tap is one cycle closer
  localparam int A_SHIFT = eae_pkg::SHIFT_CYC - 1;

  default clocking a_clk @(posedge i_clk); endclocking
  default disable iff (i_sys_rst || !i_ce);

  sequence s_started;
    seq_start_pulse ##1 (on_q && run_q && end_q);
  endsequence

  a_xfer_decode: assert property (xfer_d |=> o_transfer_enable)
    else $error("transfer enable not raised");
  a_acc_suppress: assert property (o_transfer_enable |-> !o_accum_out_enable)
    else $error("accumulator enable with transfer");
  a_cnt_enable: assert property (o_counter_out_enable |-> $past(i_memory_buffer[0]))
    else $error("counter enable without bit 11");
  a_start_sets: assert property (seq_start_pulse |-> s_started)
    else $error("start did not set flags");
  a_shift_delay: assert property (s_started |-> ##A_SHIFT raw_tp)
    else $error("shift pulse not at chain delay");
  a_run_gate: assert property (!run_q |=> !o_shift_pulse)
    else $error("shift pulse passed closed gate");
  a_tg_pulse: assert property (shift_pulse |=> !tg_q ##10 tg_q)
    else $error("time generator pulse width wrong");
  a_on_clear: assert property (shift_pulse && seq_complete && run_q |=> !on_q)
    else $error("on not cleared after completion");
  a_end_resume: assert property ($fell(end_q) |-> o_time_state_four)
    else $error("no resume pulse on end");
  a_count_step: assert property (o_counter_load |-> sc_q == $past(sc_q) + 5'h01)
    else $error("counter did not step");

endmodule // arithmetic_element_sequencer

// ### hdl/eae_pkg.sv
// constants for the arithmetic element sequencer
package eae_pkg;

  // clock and delay-chain timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int DELAY_LINE_NS  = 250;
  localparam int AMP_DELAY_NS   = 100;
  localparam int RUN_CLOCK_NS   = 450;
  localparam int TG_LOW_NS      = 100;
  localparam int SHIFT_CYC      = (DELAY_LINE_NS + AMP_DELAY_NS) / CLK_PERIOD_NS;
  localparam int RUN_CLK_CYC    = RUN_CLOCK_NS / CLK_PERIOD_NS;
  localparam int TG_LOW_CYC     = TG_LOW_NS / CLK_PERIOD_NS;

  // datapath widths
  localparam int WORD_W = 12;
  localparam int SC_W   = 5;

  // instruction bits, numbered msb-first as bit 00 .. bit 11
  localparam int MB_BIT04 = 7;
  localparam int MB_BIT06 = 5;
  localparam int MB_BIT07 = 4;
  localparam int MB_BIT11 = 0;

  // accumulator bits, msb-first numbering
  localparam int AC_BIT00 = 11;
  localparam int AC_BIT01 = 10;
  localparam int AC_BIT02 = 9;
  localparam int AC_BIT03 = 8;

  // step counter bits, msb-first numbering
  localparam int SC_BIT0 = 4;
  localparam int SC_BIT1 = 3;
  localparam int SC_BIT2 = 2;
  localparam int SC_BIT3 = 1;
  localparam int SC_BIT4 = 0;

  // full instruction codes (octal 7421 and 7441)
  localparam logic [11:0] LOAD_QUOTIENT_CODE   = 12'hF11;
  localparam logic [11:0] COUNTER_TO_ACCUM_CODE = 12'hF21;

  // register map, byte addresses
  localparam int          ADR_W        = 8;
  localparam logic [7:0]  CTRL_ADDR    = 8'h00;
  localparam logic [7:0]  STATUS_ADDR  = 8'h04;
  localparam logic [7:0]  COUNT_ADDR   = 8'h08;
  localparam logic [31:0] CTRL_RESET   = 32'h00000001;
  localparam int          CTRL_ENABLE  = 0;
  localparam int          ST_ON        = 0;
  localparam int          ST_RUN       = 1;
  localparam int          ST_END       = 2;
  localparam int          ST_TG        = 3;
  localparam int          ST_COMPLETE  = 4;
  localparam int          COUNT_SC_LSB = 0;
  localparam int          COUNT_MQ_LSB = 16;

endpackage

// ### test/eae_host_model.sv
// host processor timing model facing the arithmetic element sequencer
`timescale 1ns/1ns

module eae_host_model (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  // bench commands
  input  wire logic i_go,
  input  wire logic i_hold,
  // resume request from the sequencer
  input  wire logic i_time_state_four,
  // processor timing towards the sequencer
  output logic      o_second_operate_phase,
  output logic      o_step_one,
  output logic      o_time_pulse_three,
  output logic      o_paused
);
  logic [2:0] phase_q;

  // fetch phase counter, five cycles of second operate phase per go
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      phase_q <= 3'h0;
    end else if (i_go) begin
      phase_q <= 3'h1;
    end else if (phase_q != 3'h0) begin
      phase_q <= (phase_q == 3'h5) ? 3'h0 : phase_q + 3'h1;
    end
  end

  assign o_second_operate_phase = (phase_q != 3'h0);
  assign o_step_one             = (phase_q == 3'h2);
  assign o_time_pulse_three     = (phase_q == 3'h3);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_paused <= 1'b0;
    end else if (o_time_pulse_three && i_hold) begin
      o_paused <= 1'b1;
    end else if (i_time_state_four) begin
      o_paused <= 1'b0;
    end
  end
endmodule // eae_host_model

// ### test/arithmetic_element_sequencer_test.sv
// self-checking bench for the arithmetic element sequencer
`timescale 1ns/1ns

`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin failures++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end

module arithmetic_element_sequencer_test;
  // bench bookkeeping
  int          failures = 0;
  int          checks = 0;
  int          cyc_n = 0;
  int          shifts = 0, gap = 0, tg_low = 0, ts4 = 0, on_fall = 0, run_lag = 0, last_sp = 0;
  logic        on_d = 1'b0, run_d = 1'b0, go = 1'b0, hold = 1'b0, host_paused;
  logic [31:0] rd;
  // design inputs
  logic        i_clk = 1'b0, i_sys_rst = 1'b1, i_ce = 1'b1;
  logic        i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
  logic [7:0]  i_wb_adr = 8'h00;
  logic [31:0] i_wb_dat = 32'h00000000;
  logic [3:0]  i_wb_sel = 4'h0;
  logic [11:0] i_memory_buffer = 12'h000, i_accumulator = 12'h000;
  logic        i_second_operate_phase, i_time_pulse_three, i_step_one;
  logic        i_operate_class = 1'b1, i_execute_cycle = 1'b0, i_eae_decode = 1'b1;
  logic        i_multiply_op = 1'b0, i_divide_op = 1'b0, i_normalize_op = 1'b0;
  logic        i_shift_op = 1'b0, i_counter_load_op = 1'b0, i_adder_carry = 1'b0;
  // design outputs
  logic [31:0] o_wb_dat;
  logic [11:0] o_counter_to_accum, o_quotient;
  logic [4:0]  o_step_counter;
  logic        o_wb_ack, o_transfer_enable, o_accum_out_enable, o_counter_out_enable;
  logic        o_shift_pulse, o_quotient_load, o_counter_load, o_time_state_four;
  logic        o_seq_on_flag, o_seq_run_flag, o_seq_end_flag, o_time_generator_flag;

  arithmetic_element_sequencer dut_u (.i_clk, .i_sys_rst, .i_ce, .i_wb_cyc, .i_wb_stb,
    .i_wb_we, .i_wb_adr, .i_wb_dat, .i_wb_sel, .o_wb_dat, .o_wb_ack, .i_memory_buffer,
    .i_second_operate_phase, .i_time_pulse_three, .i_step_one, .i_operate_class,
    .i_execute_cycle, .i_eae_decode, .i_multiply_op, .i_divide_op, .i_normalize_op,
    .i_shift_op, .i_counter_load_op, .i_accumulator, .i_adder_carry, .o_transfer_enable,
    .o_accum_out_enable, .o_counter_out_enable, .o_counter_to_accum, .o_quotient,
    .o_step_counter, .o_shift_pulse, .o_quotient_load, .o_counter_load, .o_time_state_four,
    .o_seq_on_flag, .o_seq_run_flag, .o_seq_end_flag, .o_time_generator_flag);

  eae_host_model host_u (.i_clk, .i_sys_rst, .i_go(go), .i_hold(hold),
    .i_time_state_four(o_time_state_four), .o_second_operate_phase(i_second_operate_phase),
    .o_step_one(i_step_one), .o_time_pulse_three(i_time_pulse_three),
    .o_paused(host_paused));

  // free-running clock
  always #(eae_pkg::CLK_PERIOD_NS / 2) i_clk = ~i_clk;

  // pulse counting and watchdog, sampled as seen at each edge
  always @(posedge i_clk) begin
    cyc_n++;
    if (o_shift_pulse === 1'b1) begin
      shifts++;
      gap = cyc_n - last_sp;
      last_sp = cyc_n;
    end
    if (o_time_generator_flag === 1'b0) tg_low++;
    if (o_time_state_four === 1'b1) ts4++;
    if (on_d === 1'b1 && o_seq_on_flag === 1'b0) on_fall = cyc_n;
    if (run_d === 1'b1 && o_seq_run_flag === 1'b0) run_lag = cyc_n - on_fall;
    on_d = o_seq_on_flag;
    run_d = o_seq_run_flag;
    // generous ceiling: the whole run needs about 2150 cycles
    if (cyc_n == 20000) begin
      failures++;
      $display("mismatch watchdog expected done seen hang");
      results();
    end
  end

  // closing report
  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // classic wishbone single cycle, waits for ack
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                    output logic [31:0] rdat);
    int k;
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= we;
    i_wb_adr <= adr;
    i_wb_dat <= wd;
    i_wb_sel <= 4'hF;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_wb_ack !== 1'b1 && k < 50);
    if (o_wb_ack !== 1'b1) begin
      failures++;
      $display("mismatch wb ack expected 1 seen 0");
    end
    rdat = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    @(posedge i_clk);
  endtask

  // one fetch phase from the host model
  task automatic fetch(input logic [11:0] mb, input logic hld);
    i_memory_buffer <= mb;
    hold <= hld;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
  endtask

  // sel: 0 shift, 1 divide, 2 normalize, 3 multiply
  task automatic run_seq(input int sel, input logic [11:0] mb, input logic [11:0] acc,
                         input logic carry, input int exp_n);
    int k;
    i_shift_op <= (sel == 0);
    i_divide_op <= (sel == 1);
    i_normalize_op <= (sel == 2);
    i_multiply_op <= (sel == 3);
    i_execute_cycle <= (sel != 2);
    i_accumulator <= acc;
    i_adder_carry <= carry;
    shifts = 0;
    tg_low = 0;
    ts4 = 0;
    run_lag = 0;
    fetch(mb, 1'b1);
    repeat (4) @(posedge i_clk);
    for (k = 0; k < 3000 && host_paused === 1'b1; k++) @(posedge i_clk);
    // idle long enough for any stray pulse to show up
    repeat (150) @(posedge i_clk);
    i_execute_cycle <= 1'b0;
    `CHK("shift count", exp_n, shifts)
    `CHK("tg low cycles", exp_n * eae_pkg::TG_LOW_CYC, tg_low)
    `CHK("resume pulses", 1, ts4)
    `CHK("run lag", eae_pkg::RUN_CLK_CYC - eae_pkg::SHIFT_CYC, run_lag)
    `CHK("idle flags", 4'h8, {o_time_generator_flag, o_seq_end_flag, o_seq_run_flag,
         o_seq_on_flag})
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    `CHK("reset flags", 4'h8, {o_time_generator_flag, o_seq_end_flag, o_seq_run_flag,
         o_seq_on_flag})
    wb(1'b0, eae_pkg::CTRL_ADDR, 32'h00000000, rd);
    `CHK("ctrl", eae_pkg::CTRL_RESET, rd)
    wb(1'b1, eae_pkg::STATUS_ADDR, 32'hFFFFFFFF, rd);
    wb(1'b0, eae_pkg::STATUS_ADDR, 32'h00000000, rd);
    `CHK("status", 32'h1 << eae_pkg::ST_TG, rd)
    wb(1'b0, 8'h0C, 32'h00000000, rd);
    `CHK("unmapped", 32'h00000000, rd)
    // quotient load from accumulator
    i_accumulator <= 12'hA5C;
    fetch(eae_pkg::LOAD_QUOTIENT_CODE, 1'b0);
    repeat (3) @(posedge i_clk);
    `CHK("transfer enable", 1'b1, o_transfer_enable)
    `CHK("accum enable", 1'b0, o_accum_out_enable)
    repeat (4) @(posedge i_clk);
    `CHK("quotient", 12'hA5C, o_quotient)
    `CHK("transfer idle", 1'b0, o_transfer_enable)
    // shift sequences, one per completion term except the normalize all-zero term
    run_seq(0, 12'hF03, 12'h000, 1'b0, 4);
    run_seq(1, 12'hF01, 12'h000, 1'b1, 1);
    run_seq(1, 12'hF01, 12'h000, 1'b0, 14);
    run_seq(2, 12'hF01, 12'h200, 1'b0, 1);
    run_seq(3, 12'hF01, 12'h000, 1'b0, 12);
    `CHK("shift spacing", eae_pkg::SHIFT_CYC, gap)
    `CHK("step counter", 5'h0C, o_step_counter)
    // step counter into accumulator
    fetch(eae_pkg::COUNTER_TO_ACCUM_CODE, 1'b0);
    repeat (3) @(posedge i_clk);
    `CHK("counter enable", 1'b1, o_counter_out_enable)
    `CHK("accum enable", 1'b1, o_accum_out_enable)
    `CHK("counter word", 12'h00C, o_counter_to_accum)
    `CHK("transfer off", 1'b0, o_transfer_enable)
    // unnormalized operand with bits 01/02 = 1/0: the first pulse is lost
    i_normalize_op <= 1'b1;
    i_accumulator <= 12'hC00;
    shifts = 0;
    ts4 = 0;
    fetch(12'hF01, 1'b1);
    repeat (200) @(posedge i_clk);
    `CHK("lost pulse shifts", 0, shifts)
    `CHK("lost pulse resume", 1, ts4)
    `CHK("lost pulse flags", 4'h8, {o_time_generator_flag, o_seq_end_flag, o_seq_run_flag,
         o_seq_on_flag})
    // with the enable bit cleared no sequence may start
    wb(1'b1, eae_pkg::CTRL_ADDR, 32'h00000000, rd);
    fetch(12'hF01, 1'b0);
    repeat (6) @(posedge i_clk);
    `CHK("disabled start", 1'b0, o_seq_on_flag)
    i_normalize_op <= 1'b0;
    repeat (5) @(posedge i_clk);
    results();
  end
endmodule // arithmetic_element_sequencer_test
